// file: sim/link_ctrl_model.sv
`timescale 1ns/1ps
`include "dram_mode_regs_regs.svh"
// ==========================================
// memory controller on the command link
module link_ctrl_model
  import dram_mode_pkg::*;
(
  output logic            link_clk,
  output mr_cmd_t         link_cmd,
  input  wire logic       mrr_valid,
  input  wire logic [7:0] mrr_data
);
  logic [7:0] shadow_q; // controller copy of the run-time setting

  // free-running link clock, phase unrelated to the system clock
  initial
  begin
    link_clk = 1'b0;
    link_cmd = '0;
    shadow_q = 8'h00;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // one-cycle command; on release the kind bits clear and address and operand are inverted so stale values never pass
  task issue(input logic [2:0] kind, input logic [5:0] a, input logic [7:0] op);
    @(negedge link_clk);
    link_cmd <= {kind, a, op};
    @(negedge link_clk);
    link_cmd <= {3'b000, ~a, ~op};
  endtask

  task mrw(input logic [5:0] a, input logic [7:0] op);
    if (a == `ADDR_TERM_CFG && op[2:0] inside {3'h1, 3'h3, 3'h5, 3'h6}) return;
    if (a == `ADDR_STROBE_RT) shadow_q = op;
    issue(3'b100, a, op);
  endtask

  task mpc(input logic [6:0] op);
    if (op == `MPC_OSC_STOP && shadow_q != 8'h00) return;
    issue(3'b001, 6'h00, {1'b0, op});
  endtask

  // read, keeping later reads well clear of the answer
  task mrr(input logic [5:0] a, output logic [7:0] d);
    d = 8'hxx;
    issue(3'b010, a, 8'h00);
    repeat (8)
    begin
      @(posedge link_clk);
      #1;
      if (mrr_valid === 1'b1) d = mrr_data;
    end
  endtask
endmodule

// file: sim/mode_regs_checker.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module mode_regs_checker
  import dram_mode_pkg::*;
#(
  parameter logic [13:0] LONG_RUN_CLKS = 14'h2000
)
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        link_clk,
  input wire mr_cmd_t     link_cmd,
  input wire logic        mrr_valid,
  input wire logic [7:0]  mrr_data,
  input wire dev_status_t dev_status,
  input wire dev_ctrl_t   dev_ctrl
);
  // system-domain relations
  rst_vals_a:
    assert property (@(posedge clk_sys) disable iff (!nrst) $rose(nrst) |-> dev_ctrl[11:2] == 10'h070)
    else $error("defaults wrong after reset");
  term_rsvd_a:
    assert property (@(posedge clk_sys) disable iff (!nrst) dev_ctrl.controller_termination_value != 3'h7)
    else $error("reserved termination code applied");
  stop_once_a:
    assert property (@(posedge clk_sys) disable iff (!nrst) $rose(dev_ctrl.strobe_timer_auto_stop)
      |=> !dev_ctrl.strobe_timer_auto_stop) else $error("auto stop longer than one cycle");
  stop_ends_a:
    assert property (@(posedge clk_sys) disable iff (!nrst) dev_ctrl.strobe_timer_auto_stop
      |-> ##[0:1] !dev_ctrl.strobe_timer_running) else $error("timer still running after auto stop");
  stop_cause_a:
    assert property (@(posedge clk_sys) disable iff (!nrst) $rose(dev_ctrl.strobe_timer_auto_stop)
      |-> $past(dev_ctrl.strobe_timer_running)) else $error("auto stop without running timer");
  // link-domain relations
  valid_pulse_a:
    assert property (@(posedge link_clk) disable iff (!nrst) mrr_valid |=> !mrr_valid)
    else $error("read valid longer than one cycle");
  data_hold_a:
    assert property (@(posedge link_clk) disable iff (!nrst) $changed(mrr_data) |-> mrr_valid)
    else $error("read data moved without valid");
  read_answer_a:
    assert property (@(posedge link_clk) disable iff (!nrst) link_cmd.mrr |-> ##[1:4] mrr_valid)
    else $error("read not answered in time");
  cover property (@(posedge clk_sys) dev_ctrl.strobe_timer_auto_stop);
  cover property (@(posedge link_clk) mrr_valid);
  cover property (@(posedge clk_sys) $rose(dev_ctrl.targeted_row_refresh_enable));
endmodule

bind dram_mode_regs_odt_timer_trr mode_regs_checker #(.LONG_RUN_CLKS(LONG_RUN_CLKS)) mode_regs_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .link_clk(link_clk), .link_cmd(link_cmd), .mrr_valid(mrr_valid),
  .mrr_data(mrr_data), .dev_status(dev_status), .dev_ctrl(dev_ctrl));

// file: sim/tb.sv
`timescale 1ns/1ps
`include "dram_mode_regs_regs.svh"
// ==========================================
// testbench
module tb
  import dram_mode_pkg::*;
;
  logic        clk_sys;
  logic        nrst;
  logic        link_clk;
  mr_cmd_t     link_cmd;
  logic        mrr_valid;
  logic [7:0]  mrr_data;
  dev_status_t dev_status;
  dev_ctrl_t   dev_ctrl;
  logic [7:0]  rd;
  int          n_errors;
  int          tests_run;
  int          n;
  int          n_stop = 0;
  localparam logic [7:0] RT_CODE [5] = '{8'h02, 8'h3f, 8'h40, 8'h80, 8'hc0};
  localparam int         RT_LEN  [5] = '{32, 1008, 2048, 4096, 64};

  dram_mode_regs_odt_timer_trr #(.LONG_RUN_CLKS(14'h0040)) dram_mode_regs_odt_timer_trr_inst (
    .clk_sys(clk_sys), .nrst(nrst), .link_clk(link_clk), .link_cmd(link_cmd), .mrr_valid(mrr_valid),
    .mrr_data(mrr_data), .dev_status(dev_status), .dev_ctrl(dev_ctrl));
  link_ctrl_model link_ctrl_model_inst (
    .link_clk(link_clk), .link_cmd(link_cmd), .mrr_valid(mrr_valid), .mrr_data(mrr_data));

  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // auto stop pulses counted on the falling edge, where the one-cycle pulse is settled
  always @(negedge clk_sys)
  begin
    if (dev_ctrl.strobe_timer_auto_stop === 1'b1)
    begin
      n_stop++;
    end
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task settle;
    repeat (3) @(posedge link_clk);
    @(negedge clk_sys);
  endtask

  task t_reset;
    check("ctrl_rst", dev_ctrl, 12'h1c0);
    link_ctrl_model_inst.mrr(`ADDR_TERM_CFG, rd);
    check("term_rst", rd, 8'h00);
    link_ctrl_model_inst.mrr(`ADDR_STROBE_RT, rd);
    check("rt_read", rd, 8'h00);
  endtask

  // value, clock, select and command termination bits: dev_ctrl[11:6]
  task t_term;
    link_ctrl_model_inst.mrw(`ADDR_TERM_CFG, 8'h3a);
    settle;
    check("term_sp0", dev_ctrl[11:6], 6'h10);
    dev_status.write_set_point_select = 1'b1;
    link_ctrl_model_inst.mrw(`ADDR_TERM_CFG, 8'h07);
    settle;
    check("term_idle", dev_ctrl[11:6], 6'h10);
    link_ctrl_model_inst.mrr(`ADDR_TERM_CFG, rd);
    check("term_rd1", rd, 8'h07);
    @(negedge clk_sys) dev_status.operating_set_point_select = 1'b1;
    settle;
    check("term_sp1", dev_ctrl[11:6], 6'h07);
    dev_status.write_set_point_select = 1'b0;
    link_ctrl_model_inst.mrr(`ADDR_TERM_CFG, rd);
    check("term_rd0", rd, 8'h3a);
    // only the select termination disabled, value divide-by-4
    @(negedge clk_sys) dev_status.operating_set_point_select = 1'b0;
    link_ctrl_model_inst.mrw(`ADDR_TERM_CFG, 8'h14);
    settle;
    check("term_mix", dev_ctrl[11:6], 6'h25);
  endtask

  task t_trr;
    link_ctrl_model_inst.mrw(`ADDR_ROW_HAMMER, 8'hd0);
    settle;
    check("trr_ctrl", dev_ctrl[5:2], 4'hd);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys) dev_status.max_activate_count = i[2:0];
      link_ctrl_model_inst.mrr(`ADDR_ROW_HAMMER, rd);
      check("mac", rd, {4'hd, 1'b0, i[2:0]});
    end
    @(negedge clk_sys) dev_status.unlimited_activate = 1'b1;
    link_ctrl_model_inst.mrr(`ADDR_ROW_HAMMER, rd);
    check("mac_unlim", rd, 8'hd8);
    @(negedge clk_sys) dev_status.refresh_management_support = 1'b1;
    dev_status.initial_activate_threshold = 5'h05;
    link_ctrl_model_inst.mrw(`ADDR_ROW_HAMMER, 8'h00);
    settle;
    check("trr_hold", dev_ctrl[5:2], 4'hd);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk_sys) {dev_status.maximum_activate_threshold, dev_status.refresh_management_required} = {i[1:0], i[0]};
      link_ctrl_model_inst.mrr(`ADDR_ROW_HAMMER, rd);
      check("rfm", rd, {i[1:0], 5'h05, i[0]});
    end
  endtask

  // run length counted in link clocks from the start command
  task t_timer;
    link_ctrl_model_inst.mpc(`MPC_OSC_START);
    repeat (1100) @(posedge link_clk);
    check("rt_zero", dev_ctrl.strobe_timer_running, 1'b1);
    link_ctrl_model_inst.mpc(`MPC_OSC_STOP);
    settle;
    check("rt_stop", dev_ctrl.strobe_timer_running, 1'b0);
    check("stop_quiet", 16'(n_stop), 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      link_ctrl_model_inst.mrw(`ADDR_STROBE_RT, RT_CODE[i]);
      link_ctrl_model_inst.mpc(`MPC_OSC_START);
      n = 4;
      repeat (4) @(posedge link_clk);
      while (dev_ctrl.strobe_timer_running === 1'b1 && n < 9000)
      begin
        @(posedge link_clk);
        n++;
      end
      check("run_len", (n > RT_LEN[i] - 3 && n < RT_LEN[i] + 4) ? RT_LEN[i] : n, RT_LEN[i]);
      check("stop_pulse", 16'(n_stop), 16'(i + 1));
    end
  endtask

  // watchdog
  initial
  begin
    repeat (70000) @(posedge clk_sys);
    n_errors++;
    give_verdict;
  end

  // main sequence
  initial
  begin
    nrst = 1'b0;
    dev_status = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge link_clk);
    @(negedge clk_sys) nrst = 1'b1;
    repeat (4) @(posedge link_clk);
    t_reset;
    t_term;
    t_trr;
    t_timer;
    give_verdict;
  end
endmodule

// file: src/dram_mode_pkg.sv
package dram_mode_pkg;

  // command seen on the link, already decoded from the command bus
  typedef struct packed {
    logic       mrw;
    logic       mrr;
    logic       mpc;
    logic [5:0] addr;
    logic [7:0] op;
  } mr_cmd_t;

  // device-side status and set-point selection on the system clock
  typedef struct packed {
    logic       write_set_point_select;
    logic       operating_set_point_select;
    logic       refresh_management_support;
    logic [2:0] max_activate_count;
    logic       unlimited_activate;
    logic       refresh_management_required;
    logic [4:0] initial_activate_threshold;
    logic [1:0] maximum_activate_threshold;
  } dev_status_t;

  // settings applied to the device core
  typedef struct packed {
    logic [2:0] controller_termination_value;
    logic       clock_input_termination_enable;
    logic       select_input_termination_enable;
    logic       command_bus_termination_enable;
    logic       targeted_row_refresh_enable;
    logic [2:0] targeted_row_refresh_bank;
    logic       strobe_timer_running;
    logic       strobe_timer_auto_stop;
  } dev_ctrl_t;

  typedef enum logic [1:0] {
    OSC_IDLE = 2'b01,
    OSC_RUN  = 2'b10
  } osc_state_t;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    mr_cmd_t    cmd;
    logic       req_tgl;
    logic       tick_tgl;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic       mrr_pend;
    logic       mrr_valid;
    logic [7:0] mrr_data;
  } link_state_t;

  typedef struct packed {
    logic            req_s1;
    logic            req_s2;
    logic            req_s3;
    logic            tick_s1;
    logic            tick_s2;
    logic            tick_s3;
    logic [1:0][7:0] term;
    logic [7:0]      runtime;
    logic            trr_en;
    logic [2:0]      trr_bank;
    osc_state_t      osc;
    logic [13:0]     osc_cnt;
    logic [7:0]      rdata;
    logic            ack_tgl;
    dev_ctrl_t       ctrl;
  } sys_state_t;

endpackage

// file: src/dram_mode_regs_odt_timer_trr.sv
`timescale 1ns/1ps
`include "dram_mode_regs_regs.svh"
module dram_mode_regs_odt_timer_trr
  import dram_mode_pkg::*;
#(
  parameter logic [13:0] LONG_RUN_CLKS = `RT_CLKS_8K
)
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        link_clk,
  input  wire mr_cmd_t     link_cmd,
  output logic             mrr_valid,
  output logic [7:0]       mrr_data,
  input  wire dev_status_t dev_status,
  output dev_ctrl_t        dev_ctrl
);

  // ==========================================================
  // helpers

  // automatic stop point in link clocks, zero meaning none
  function automatic logic [13:0] run_limit(input logic [7:0] rt);
    logic [13:0] lim;
    lim = 14'h0000;
    case (rt[`RT_MODE_MSB:`RT_MODE_LSB])
      `RT_MODE_SHORT: lim = {4'h0, rt, 2'h0} << 2;
      `RT_MODE_2K:    lim = `RT_CLKS_2K;
      `RT_MODE_4K:    lim = `RT_CLKS_4K;
      default:        lim = LONG_RUN_CLKS;
    endcase
    return lim;
  endfunction

  // row hammer register as read back, layout chosen by support bit
  function automatic logic [7:0] row_hammer_read(input dev_status_t st,
                                                  input logic        en,
                                                  input logic [2:0]  bank);
    logic [7:0] v;
    v = 8'h00;
    if (st.refresh_management_support)
    begin
      v = {st.maximum_activate_threshold,
           st.initial_activate_threshold,
           st.refresh_management_required};
    end
    else
    begin
      v[`RH_TRR_BIT]               = en;
      v[`RH_BANK_MSB:`RH_BANK_LSB] = bank;
      v[`RH_UNLIM_BIT]             = st.unlimited_activate;
      v[`RH_MAC_MSB:`RH_MAC_LSB]   = st.unlimited_activate ? `MAC_CODE_UNLIM
                                                           : st.max_activate_count;
    end
    return v;
  endfunction

  // ==========================================================
  // link domain: capture commands, pace ticks, return reads

  link_state_t l_q;
  link_state_t l_d;
  sys_state_t  s_q;
  sys_state_t  s_d;

  // link side state update
  always_comb
  begin
    l_d           = l_q;
    l_d.rst_s1    = nrst;
    l_d.rst_s2    = l_q.rst_s1;
    l_d.ack_s1    = s_q.ack_tgl;
    l_d.ack_s2    = l_q.ack_s1;
    l_d.ack_s3    = l_q.ack_s2;
    l_d.tick_tgl  = ~l_q.tick_tgl;                                   // one toggle per link clock
    l_d.mrr_valid = 1'b0;
    if (link_cmd.mrw || link_cmd.mrr || link_cmd.mpc)
    begin
      l_d.cmd     = link_cmd;                                        // held until the next command
      l_d.req_tgl = ~l_q.req_tgl;
      if (link_cmd.mrr)
      begin
        l_d.mrr_pend = 1'b1;
      end
    end
    if (l_q.mrr_pend && (l_q.ack_s2 != l_q.ack_s3))
    begin
      l_d.mrr_pend  = 1'b0;
      l_d.mrr_valid = 1'b1;
      l_d.mrr_data  = s_q.rdata;                                     // stable since the ack toggled
    end
    if (!l_q.rst_s2)
    begin
      l_d.cmd       = '0;
      l_d.req_tgl   = 1'b0;
      l_d.tick_tgl  = 1'b0;
      l_d.ack_s1    = 1'b0;
      l_d.ack_s2    = 1'b0;
      l_d.ack_s3    = 1'b0;
      l_d.mrr_pend  = 1'b0;
      l_d.mrr_valid = 1'b0;
      l_d.mrr_data  = 8'h00;
    end
  end

  // link side registers
  always_ff @(posedge link_clk)
  begin
    l_q <= l_d;
  end

  assign mrr_valid = l_q.mrr_valid;
  assign mrr_data  = l_q.mrr_data;

  // ==========================================================
  // system domain: register bank, timer, outputs

  logic        req_evt;
  logic        tick_evt;
  logic [13:0] limit;
  logic [13:0] cnt_next;
  logic [7:0]  wr_copy;
  logic [7:0]  act_copy;

  // system side state update
  always_comb
  begin
    s_d         = s_q;
    s_d.req_s1  = l_q.req_tgl;
    s_d.req_s2  = s_q.req_s1;
    s_d.req_s3  = s_q.req_s2;
    s_d.tick_s1 = l_q.tick_tgl;
    s_d.tick_s2 = s_q.tick_s1;
    s_d.tick_s3 = s_q.tick_s2;
    req_evt     = s_q.req_s2 != s_q.req_s3;
    tick_evt    = s_q.tick_s2 != s_q.tick_s3;
    limit       = run_limit(s_q.runtime);
    cnt_next    = s_q.osc_cnt + 14'h0001;
    wr_copy     = s_q.term[dev_status.write_set_point_select];
    act_copy    = s_q.term[dev_status.operating_set_point_select];
    s_d.ctrl.strobe_timer_auto_stop = 1'b0;

    // commands handed over from the link, held stable there
    if (req_evt && l_q.cmd.mrw)
    begin
      if (l_q.cmd.addr == `ADDR_TERM_CFG)
      begin
        s_d.term[dev_status.write_set_point_select] = l_q.cmd.op;
      end
      else if (l_q.cmd.addr == `ADDR_STROBE_RT)
      begin
        s_d.runtime = l_q.cmd.op;
      end
      else if ((l_q.cmd.addr == `ADDR_ROW_HAMMER) && !dev_status.refresh_management_support)
      begin
        s_d.trr_en   = l_q.cmd.op[`RH_TRR_BIT];
        s_d.trr_bank = l_q.cmd.op[`RH_BANK_MSB:`RH_BANK_LSB];
      end
    end
    if (req_evt && l_q.cmd.mrr)
    begin
      if (l_q.cmd.addr == `ADDR_TERM_CFG)
      begin
        s_d.rdata = wr_copy;
      end
      else if (l_q.cmd.addr == `ADDR_ROW_HAMMER)
      begin
        s_d.rdata = row_hammer_read(dev_status, s_q.trr_en, s_q.trr_bank);
      end
      else
      begin
        s_d.rdata = 8'h00;
      end
      s_d.ack_tgl = ~s_q.ack_tgl;
    end

    // strobe interval timer
    case (s_q.osc)
      OSC_IDLE:
      begin
        if (req_evt && l_q.cmd.mpc && (l_q.cmd.op[6:0] == `MPC_OSC_START))
        begin
          s_d.osc     = OSC_RUN;
          s_d.osc_cnt = 14'h0000;
        end
      end
      OSC_RUN:
      begin
        if (req_evt && l_q.cmd.mpc && (l_q.cmd.op[6:0] == `MPC_OSC_STOP)
            && (s_q.runtime == `RUNTIME_RESET))
        begin
          s_d.osc = OSC_IDLE;
        end
        else if (tick_evt)
        begin
          s_d.osc_cnt = cnt_next;
          if ((limit != 14'h0000) && (cnt_next >= limit))
          begin
            s_d.osc                         = OSC_IDLE;
            s_d.ctrl.strobe_timer_auto_stop = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.osc = OSC_IDLE;
      end
    endcase

    // settings applied to the core, termination from the active copy only
    if (act_copy[`TERM_VAL_MSB:`TERM_VAL_LSB] == `TERM_CODE_RSVD)
    begin
      s_d.ctrl.controller_termination_value = `TERM_CODE_OFF;
    end
    else
    begin
      s_d.ctrl.controller_termination_value = act_copy[`TERM_VAL_MSB:`TERM_VAL_LSB];
    end
    s_d.ctrl.clock_input_termination_enable  = ~act_copy[`TERM_CK_BIT];
    s_d.ctrl.select_input_termination_enable = ~act_copy[`TERM_CS_BIT];
    s_d.ctrl.command_bus_termination_enable  = ~act_copy[`TERM_CA_BIT];
    s_d.ctrl.targeted_row_refresh_enable     = s_d.trr_en;
    s_d.ctrl.targeted_row_refresh_bank       = s_d.trr_bank;
    s_d.ctrl.strobe_timer_running            = s_d.osc == OSC_RUN;

    if (!nrst)
    begin
      s_d                                      = '0;
      s_d.term                                 = {`TERM_RESET, `TERM_RESET};
      s_d.runtime                              = `RUNTIME_RESET;
      s_d.trr_bank                             = `TRR_BANK_RESET;
      s_d.osc                                  = OSC_IDLE;
      s_d.ctrl.clock_input_termination_enable  = 1'b1;
      s_d.ctrl.select_input_termination_enable = 1'b1;
      s_d.ctrl.command_bus_termination_enable  = 1'b1;
    end
  end

  // system side registers
  always_ff @(posedge clk_sys)
  begin
    s_q <= s_d;
  end

  assign dev_ctrl = s_q.ctrl;

endmodule

// file: src/dram_mode_regs_regs.svh
`ifndef DRAM_MODE_REGS_REGS_SVH
`define DRAM_MODE_REGS_REGS_SVH

// ==========================================================
// mode-register addresses
`define ADDR_TERM_CFG       6'h16
`define ADDR_STROBE_RT      6'h17
`define ADDR_ROW_HAMMER     6'h18

// ==========================================================
// multipurpose command operands
`define MPC_OSC_STOP        7'h4d
`define MPC_OSC_START       7'h4c

// ==========================================================
// reset values
`define TERM_RESET          8'h00
`define RUNTIME_RESET       8'h00
`define TRR_BANK_RESET      3'h0

// ==========================================================
// termination_config field positions
`define TERM_VAL_LSB        0
`define TERM_VAL_MSB        2
`define TERM_CK_BIT         3
`define TERM_CS_BIT         4
`define TERM_CA_BIT         5
`define TERM_CODE_OFF       3'h0
`define TERM_CODE_RSVD      3'h7

// ==========================================================
// row_hammer_control field positions
`define RH_MAC_LSB          0
`define RH_MAC_MSB          2
`define RH_UNLIM_BIT        3
`define RH_BANK_LSB         4
`define RH_BANK_MSB         6
`define RH_TRR_BIT          7
`define MAC_CODE_UNLIM      3'h0

// ==========================================================
// strobe timer run-time encoding, counts in link clocks
`define RT_MODE_MSB         7
`define RT_MODE_LSB         6
`define RT_MODE_SHORT       2'h0
`define RT_MODE_2K          2'h1
`define RT_MODE_4K          2'h2
`define RT_SHORT_SHIFT      4
`define RT_CLKS_2K          14'h0800
`define RT_CLKS_4K          14'h1000
`define RT_CLKS_8K          14'h2000

`endif
